// ==== common/vns_defines.svh ====
`ifndef VNS_DEFINES_SVH
`define VNS_DEFINES_SVH

// ==========================================================
// Instruction word fields
`define VNS_SCALAR_MSB     28
`define VNS_SCALAR_LSB     25
`define VNS_TYPE_BIT       8
`define VNS_SIZE_BIT       7
`define VNS_NORM_MSB       28
`define VNS_NORM_LSB       16
`define VNS_NORM_CODE      13'h01c0
`define VNS_SCL_MSB        24
`define VNS_SCL_LSB        16
`define VNS_SCL_CODE       9'h0e0

// ==========================================================
// Transfer kinds forwarded with the word
`define VNS_XFER_SHORT     2'h0
`define VNS_XFER_REG       2'h1
`define VNS_XFER_MEM       2'h2

// ==========================================================
// Precision codes toward the arithmetic core
`define VNS_PREC_INT       2'h0
`define VNS_PREC_SGL       2'h1
`define VNS_PREC_DBL       2'h2

// ==========================================================
// Register file indices
`define VNS_REG_A0         5'h00
`define VNS_REG_A1         5'h01
`define VNS_REG_A2         5'h02
`define VNS_REG_A3         5'h03
`define VNS_REG_A9         5'h09
`define VNS_REG_C          5'h0a
`define VNS_REG_TEMP2      5'h0b
`define VNS_BANK_B         1'b1

// ==========================================================
// Sequence and reset values
`define VNS_STEP_FIRST     4'h0
`define VNS_STEP_ONE       4'h1
`define VNS_NORM_LAST      4'hd
`define VNS_SCL_LAST       4'h2
`define VNS_ZERO64         64'h0000_0000_0000_0000
`define VNS_ZERO32         32'h0000_0000

`endif

// ==== common/vns_pkg.sv ====
package vns_pkg;

    // ==========================================================
    // Controller states, Gray along idle-load-issue-wait-finish
    typedef enum logic [2:0] {
        ST_IDLE   = 3'h0,
        ST_LOAD   = 3'h1,
        ST_ISSUE  = 3'h3,
        ST_WAIT   = 3'h2,
        ST_FINISH = 3'h6
    } vns_state_type;

    // ==========================================================
    // Micro-operations; moves complete locally
    typedef enum logic [2:0] {
        FOP_MOV  = 3'h0,
        FOP_MUL  = 3'h1,
        FOP_ADD  = 3'h2,
        FOP_SQRT = 3'h3,
        FOP_RCP  = 3'h4
    } vns_fop_type;

    typedef enum logic {
        KIND_NORM  = 1'b0,
        KIND_SCALE = 1'b1
    } vns_kind_type;

endpackage : vns_pkg

// ==== verilog/vns_step_rom.sv ====
`timescale 1ns/1ps
`include "vns_defines.svh"

module vns_step_rom
    import vns_pkg::*;
(
    input  wire vns_kind_type kind_i,
    input  wire logic [3:0]   step_i,
    input  wire logic [4:0]   scalar_i,
    output vns_fop_type       fop_o,
    output logic [4:0]        src_a_o,
    output logic [4:0]        src_b_o,
    output logic [4:0]        dst_o,
    output logic              last_o
);

    always_comb begin
        fop_o   = FOP_MOV;
        src_a_o = `VNS_REG_A0;
        src_b_o = `VNS_REG_A0;
        dst_o   = `VNS_REG_A0;
        last_o  = 1'b0;
        if (kind_i == KIND_SCALE) begin
            fop_o   = FOP_MUL;
            src_a_o = 5'(step_i);
            src_b_o = scalar_i;
            dst_o   = 5'(step_i);
            last_o  = (step_i == `VNS_SCL_LAST);
        end else begin
            last_o = (step_i == `VNS_NORM_LAST);
            unique case (step_i)
                4'h0: begin
                    dst_o = `VNS_REG_C;
                end
                4'h1: begin
                    fop_o = FOP_MUL; src_a_o = `VNS_REG_C; src_b_o = `VNS_REG_C; dst_o = `VNS_REG_C;
                end
                4'h2: begin
                    src_a_o = `VNS_REG_A1; dst_o = `VNS_REG_TEMP2;
                end
                4'h3: begin
                    fop_o = FOP_MUL; src_a_o = `VNS_REG_TEMP2; src_b_o = `VNS_REG_TEMP2; dst_o = `VNS_REG_A9;
                end
                4'h4: begin
                    fop_o = FOP_ADD; src_a_o = `VNS_REG_C; src_b_o = `VNS_REG_A9; dst_o = `VNS_REG_A9;
                end
                4'h5: begin
                    src_a_o = `VNS_REG_A2; dst_o = `VNS_REG_C;
                end
                4'h6: begin
                    fop_o = FOP_MUL; src_a_o = `VNS_REG_C; src_b_o = `VNS_REG_C; dst_o = `VNS_REG_C;
                end
                4'h7: begin
                    fop_o = FOP_ADD; src_a_o = `VNS_REG_C; src_b_o = `VNS_REG_A9; dst_o = `VNS_REG_A9;
                end
                4'h8: begin
                    fop_o = FOP_SQRT; src_a_o = `VNS_REG_A9; dst_o = `VNS_REG_C;
                end
                4'h9: begin
                    src_a_o = `VNS_REG_C; dst_o = `VNS_REG_A3;
                end
                4'ha: begin
                    fop_o = FOP_RCP; src_a_o = `VNS_REG_C; dst_o = `VNS_REG_C;
                end
                4'hb, 4'hc, 4'hd: begin
                    fop_o   = FOP_MUL;
                    src_a_o = `VNS_REG_C;
                    src_b_o = 5'(step_i - 4'hb);
                    dst_o   = 5'(step_i - 4'hb);
                end
                default: begin
                    last_o = 1'b1;
                end
            endcase
        end
    end

endmodule : vns_step_rom

// ==== verilog/vns_top.sv ====
`timescale 1ns/1ps
`include "vns_defines.svh"

module vns_top
    import vns_pkg::*;
(
    input  wire logic        CLK_I,
    input  wire logic        RST_B_I,
    input  wire logic        INSTR_VALID_I,
    input  wire logic [31:0] INSTR_WORD_I,
    input  wire logic [1:0]  XFER_TYPE_I,
    input  wire logic        DATA_VALID_I,
    input  wire logic [31:0] DATA_I,
    input  wire logic        WR_VALID_I,
    input  wire logic [4:0]  WR_SEL_I,
    input  wire logic [63:0] WR_DATA_I,
    input  wire logic [4:0]  RD_SEL_I,
    input  wire logic        FPU_DONE_I,
    input  wire logic [63:0] FPU_RESULT_I,
    output logic             BUSY_O,
    output logic             DATA_READY_O,
    output logic             DONE_O,
    output logic             ILLEGAL_O,
    output logic [63:0]      RD_DATA_O,
    output logic             FPU_REQ_O,
    output logic [2:0]       FPU_OP_O,
    output logic [1:0]       FPU_PREC_O,
    output logic [63:0]      FPU_A_O,
    output logic [63:0]      FPU_B_O
);

    // ==========================================================
    // Decode helpers
    function automatic logic is_norm(input logic [31:0] w);
        return w[`VNS_NORM_MSB:`VNS_NORM_LSB] == `VNS_NORM_CODE;
    endfunction : is_norm

    function automatic logic is_scale(input logic [31:0] w);
        return w[`VNS_SCL_MSB:`VNS_SCL_LSB] == `VNS_SCL_CODE;
    endfunction : is_scale

    function automatic logic [1:0] prec_of(input logic [31:0] w);
        if (!w[`VNS_TYPE_BIT]) begin
            return `VNS_PREC_INT;
        end
        return w[`VNS_SIZE_BIT] ? `VNS_PREC_DBL : `VNS_PREC_SGL;
    endfunction : prec_of

    // ==========================================================
    // State
    vns_state_type state;
    vns_kind_type  kind;
    logic [3:0]    step;
    logic [4:0]    scalar_reg;
    logic [1:0]    prec;
    logic          word_half;
    logic [63:0]   regs [0:31];

    vns_fop_type   fop;
    logic [4:0]    src_a;
    logic [4:0]    src_b;
    logic [4:0]    dst;
    logic          last;

    logic          accept;
    logic          bad;
    logic          needs_load;
    logic          load_done;

    vns_step_rom u_rom (
        .kind_i   (kind),
        .step_i   (step),
        .scalar_i (scalar_reg),
        .fop_o    (fop),
        .src_a_o  (src_a),
        .src_b_o  (src_b),
        .dst_o    (dst),
        .last_o   (last)
    );

    // ==========================================================
    // Instruction acceptance
    always_comb begin
        accept = INSTR_VALID_I && (state == ST_IDLE);
        bad = !is_scale(INSTR_WORD_I) &&
              (!is_norm(INSTR_WORD_I) || prec_of(INSTR_WORD_I) == `VNS_PREC_INT);
        needs_load = is_scale(INSTR_WORD_I) && (XFER_TYPE_I != `VNS_XFER_SHORT);
        load_done = DATA_VALID_I && (word_half || prec != `VNS_PREC_DBL);
    end

    // ==========================================================
    // Control sequence
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            state      <= ST_IDLE;
            kind       <= KIND_NORM;
            step       <= `VNS_STEP_FIRST;
            scalar_reg <= `VNS_REG_A0;
            prec       <= `VNS_PREC_INT;
            word_half  <= 1'b0;
        end else begin
            unique case (state)
                ST_IDLE: begin
                    step      <= `VNS_STEP_FIRST;
                    word_half <= 1'b0;
                    if (accept && !bad) begin
                        kind       <= is_scale(INSTR_WORD_I) ? KIND_SCALE : KIND_NORM;
                        prec       <= prec_of(INSTR_WORD_I);
                        scalar_reg <= {`VNS_BANK_B, INSTR_WORD_I[`VNS_SCALAR_MSB:`VNS_SCALAR_LSB]};
                        state      <= needs_load ? ST_LOAD : ST_ISSUE;
                    end
                end
                // memory forms deliver the same words
                // pointer handling stays on the host
                ST_LOAD: begin
                    if (DATA_VALID_I) begin
                        word_half <= 1'b1;
                    end
                    if (load_done) begin
                        state <= ST_ISSUE;
                    end
                end
                ST_ISSUE: begin
                    if (fop != FOP_MOV) begin
                        state <= ST_WAIT;
                    end else if (last) begin
                        state <= ST_FINISH;
                    end else begin
                        step <= step + `VNS_STEP_ONE;
                    end
                end
                ST_WAIT: begin
                    if (FPU_DONE_I) begin
                        if (last) begin
                            state <= ST_FINISH;
                        end else begin
                            step  <= step + `VNS_STEP_ONE;
                            state <= ST_ISSUE;
                        end
                    end
                end
                ST_FINISH: begin
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Register file; sequence writes win over the host port
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            for (int i = 0; i < 32; i++) begin
                regs[i] <= `VNS_ZERO64;
            end
        end else begin
            if (WR_VALID_I && state == ST_IDLE) begin
                regs[WR_SEL_I] <= WR_DATA_I;
            end
            // scalar loaded into named B register
            if (state == ST_LOAD && DATA_VALID_I) begin
                if (word_half) begin
                    regs[scalar_reg][63:32] <= DATA_I;
                end else begin
                    regs[scalar_reg] <= {`VNS_ZERO32, DATA_I};
                end
            end
            if (state == ST_ISSUE && fop == FOP_MOV) begin
                regs[dst] <= regs[src_a];
            end
            if (state == ST_WAIT && FPU_DONE_I) begin
                regs[dst] <= FPU_RESULT_I;
            end
        end
    end

    // ==========================================================
    // Arithmetic core request, held until done
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            FPU_REQ_O  <= 1'b0;
            FPU_OP_O   <= FOP_MOV;
            FPU_PREC_O <= `VNS_PREC_INT;
            FPU_A_O    <= `VNS_ZERO64;
            FPU_B_O    <= `VNS_ZERO64;
        end else if (state == ST_ISSUE && fop != FOP_MOV) begin
            FPU_REQ_O  <= 1'b1;
            FPU_OP_O   <= fop;
            FPU_PREC_O <= prec;
            FPU_A_O    <= regs[src_a];
            FPU_B_O    <= regs[src_b];
        end else if (FPU_DONE_I) begin
            FPU_REQ_O <= 1'b0;
        end
    end

    // ==========================================================
    // Status outputs
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            BUSY_O       <= 1'b0;
            DATA_READY_O <= 1'b0;
            DONE_O       <= 1'b0;
            ILLEGAL_O    <= 1'b0;
            RD_DATA_O    <= `VNS_ZERO64;
        end else begin
            BUSY_O       <= (state != ST_IDLE) || (accept && !bad);
            DATA_READY_O <= (state == ST_IDLE && accept && !bad && needs_load) ||
                            (state == ST_LOAD && !load_done);
            DONE_O       <= (state == ST_FINISH);
            ILLEGAL_O    <= accept && bad;
            RD_DATA_O    <= regs[RD_SEL_I];
        end
    end

endmodule : vns_top

// ==== bench/vns_chk.sv ====
`timescale 1ns/1ps

module vns_chk
    import vns_pkg::*;
(
    input  wire logic        CLK_I,
    input  wire logic        RST_B_I,
    input  wire logic        INSTR_VALID_I,
    input  wire logic [31:0] INSTR_WORD_I,
    input  wire logic [1:0]  XFER_TYPE_I,
    input  wire logic        FPU_DONE_I,
    input  wire logic        BUSY_O,
    input  wire logic        DATA_READY_O,
    input  wire logic        DONE_O,
    input  wire logic        ILLEGAL_O,
    input  wire logic        FPU_REQ_O,
    input  wire logic [2:0]  FPU_OP_O,
    input  wire logic [1:0]  FPU_PREC_O,
    input  wire logic [63:0] FPU_A_O,
    input  wire logic [63:0] FPU_B_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);

    logic [1:0] prec;
    logic       scl;
    wire        take  = INSTR_VALID_I && (!BUSY_O || DONE_O);
    wire        is_nm = INSTR_WORD_I[28:16] == 13'h01c0;
    wire        is_sc = INSTR_WORD_I[24:16] == 9'h0e0;

    // ==========================================================
    // Expected precision held for the whole operation
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            prec <= 2'h0;
            scl  <= 1'b0;
        end else if (take) begin
            prec <= !INSTR_WORD_I[8] ? 2'h0 : (INSTR_WORD_I[7] ? 2'h2 : 2'h1);
            scl  <= is_sc;
        end
    end

    // ==========================================================
    // Properties
    a_done_pulse: // no tag
        assert property (DONE_O |=> !DONE_O) else $error("done lasted over one cycle");
    a_busy_end:
        assert property (DONE_O && !INSTR_VALID_I |-> BUSY_O ##1 !BUSY_O) else $error("busy end wrong");
    a_busy_cause:
        assert property ($rose(BUSY_O) |-> $past(INSTR_VALID_I)) else $error("busy rose without word");
    a_norm_int_refuse:
        assert property (take && is_nm && !INSTR_WORD_I[8] |=> ILLEGAL_O && !BUSY_O)
        else $error("integer normalise not refused");
    a_prec_match:
        assert property (FPU_REQ_O |-> FPU_PREC_O == prec) else $error("precision differs from word");
    a_scale_mul:
        assert property (FPU_REQ_O && scl |-> FPU_OP_O == 3'h1) else $error("scale used non multiply");
    a_scalar_load:
        assert property (take && is_sc && XFER_TYPE_I != 2'h0 |=> DATA_READY_O ##0 !FPU_REQ_O)
        else $error("scalar not loaded first");
    a_req_hold:
        assert property (FPU_REQ_O && !FPU_DONE_I |=> FPU_REQ_O && $stable(FPU_A_O) && $stable(FPU_B_O)
                         && $stable(FPU_OP_O)) else $error("request moved before done");
    a_req_drop:
        assert property (FPU_REQ_O && FPU_DONE_I |=> !FPU_REQ_O) else $error("request held after done");
endmodule : vns_chk

// ==== bench/vns_core_model.sv ====
`timescale 1ns/1ps

module vns_core_model
    import vns_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        req_i,
    input  wire logic [2:0]  op_i,
    input  wire logic [63:0] a_i,
    input  wire logic [63:0] b_i,
    output logic             done_o,
    output logic [63:0]      res_o
);
    logic [1:0] wait_cnt;
    logic       held;
    logic       slow;

    // ==========================================================
    // Stand-in arithmetic, latency alternates prompt and slow
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            done_o   <= 1'b0;
            res_o    <= 64'h0;
            wait_cnt <= 2'h0;
            held     <= 1'b0;
            slow     <= 1'b0;
        end else begin
            done_o <= 1'b0;
            // Stale result inverted every cycle, never held
            res_o  <= ~res_o;
            if (!req_i) begin
                held     <= 1'b0;
                wait_cnt <= slow ? 2'h2 : 2'h0;
            end else if (!held && wait_cnt != 2'h0) begin
                wait_cnt <= wait_cnt - 2'h1;
            end else if (!held) begin
                done_o <= 1'b1;
                held   <= 1'b1;
                slow   <= !slow;
                case (op_i)
                    FOP_MUL:  res_o <= a_i * b_i;
                    FOP_ADD:  res_o <= a_i + b_i;
                    FOP_SQRT: res_o <= a_i >> 1;
                    default:  res_o <= ~a_i;
                endcase
            end
        end
    end
endmodule : vns_core_model

// ==== bench/testbench.sv ====
`timescale 1ns/1ps

module testbench
    import vns_pkg::*;
;
    logic        CLK_I, RST_B_I, INSTR_VALID_I, DATA_VALID_I, WR_VALID_I, FPU_DONE_I;
    logic [31:0] INSTR_WORD_I, DATA_I;
    logic [1:0]  XFER_TYPE_I, FPU_PREC_O;
    logic [4:0]  WR_SEL_I, RD_SEL_I;
    logic [63:0] WR_DATA_I, FPU_RESULT_I, RD_DATA_O, FPU_A_O, FPU_B_O;
    logic        BUSY_O, DATA_READY_O, DONE_O, ILLEGAL_O, FPU_REQ_O;
    logic [2:0]  FPU_OP_O;
    logic [63:0] exp_q[$];
    logic        rd_req, rd_q;
    logic [31:0] seed;
    int          err_total, checks;

    vns_top dut (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .INSTR_VALID_I(INSTR_VALID_I),
        .INSTR_WORD_I(INSTR_WORD_I), .XFER_TYPE_I(XFER_TYPE_I), .DATA_VALID_I(DATA_VALID_I),
        .DATA_I(DATA_I), .WR_VALID_I(WR_VALID_I), .WR_SEL_I(WR_SEL_I), .WR_DATA_I(WR_DATA_I),
        .RD_SEL_I(RD_SEL_I), .FPU_DONE_I(FPU_DONE_I), .FPU_RESULT_I(FPU_RESULT_I), .BUSY_O(BUSY_O),
        .DATA_READY_O(DATA_READY_O), .DONE_O(DONE_O), .ILLEGAL_O(ILLEGAL_O), .RD_DATA_O(RD_DATA_O),
        .FPU_REQ_O(FPU_REQ_O), .FPU_OP_O(FPU_OP_O), .FPU_PREC_O(FPU_PREC_O), .FPU_A_O(FPU_A_O),
        .FPU_B_O(FPU_B_O));
    vns_core_model core (.clk_i(CLK_I), .rst_b_i(RST_B_I), .req_i(FPU_REQ_O), .op_i(FPU_OP_O),
        .a_i(FPU_A_O), .b_i(FPU_B_O), .done_o(FPU_DONE_I), .res_o(FPU_RESULT_I));

    initial begin
        CLK_I = 1'b0;
        forever #2.5 CLK_I = ~CLK_I;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic end_sim();
        $display("err_total=%0d checks=%0d", err_total, checks);
        if (err_total == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_sim

    task automatic cmp(input logic [63:0] g, input logic [63:0] e);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask : cmp

    task automatic wr(input logic [4:0] sel, input logic [63:0] d);
        @(posedge CLK_I);
        WR_VALID_I <= 1'b1;
        WR_SEL_I   <= sel;
        WR_DATA_I  <= d;
        @(posedge CLK_I);
        WR_VALID_I <= 1'b0;
    endtask : wr

    // Expectation noted now, compared by the monitor
    task automatic rd(input logic [4:0] sel, input logic [63:0] e);
        exp_q.push_back(e);
        @(posedge CLK_I);
        RD_SEL_I <= sel;
        rd_req   <= 1'b1;
        @(posedge CLK_I);
        rd_req   <= 1'b0;
    endtask : rd

    task automatic run(input logic [31:0] w, input logic [1:0] xt, input logic [31:0] d0, d1,
                       input int n, input logic ill);
        int k;
        @(posedge CLK_I);
        INSTR_VALID_I <= 1'b1;
        INSTR_WORD_I  <= w;
        XFER_TYPE_I   <= xt;
        @(posedge CLK_I);
        INSTR_VALID_I <= 1'b0;
        DATA_VALID_I  <= n > 0;
        DATA_I        <= d0;
        #1;
        if (ill) begin
            cmp({ILLEGAL_O, BUSY_O}, 2'b10);
            return;
        end
        if (n > 1) begin
            @(posedge CLK_I);
            DATA_I <= d1;
        end
        @(posedge CLK_I);
        DATA_VALID_I <= 1'b0;
        for (k = 0; k < 300 && DONE_O !== 1'b1; k++) begin
            @(posedge CLK_I);
            #1;
        end
        if (k >= 300) begin
            err_total++;
            end_sim();
        end
        @(posedge CLK_I);
        #1;
    endtask : run

    always @(posedge CLK_I) begin
        rd_q <= rd_req;
        if (rd_q)
            cmp(RD_DATA_O, exp_q.pop_front());
    end

    // Scale variants: transfer kind, type, size
    logic [1:0]  xk[7] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h1, 2'h2, 2'h2};
    logic        tk[7] = '{1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
    logic        sk[7] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0};
    logic [63:0] x, y, z, c, a9, m, sv;
    logic [31:0] host_operand_first, host_operand_second, host_pointer_register, hmem[16];
    logic [3:0]  coproc_scale_source;
    initial begin
        {INSTR_VALID_I, DATA_VALID_I, WR_VALID_I, rd_req} = 4'h0;
        {INSTR_WORD_I, DATA_I, XFER_TYPE_I, WR_SEL_I, RD_SEL_I, WR_DATA_I} = '0;
        seed = 32'h11;
        err_total = 0;
        checks = 0;
        RST_B_I = 1'b0;
        repeat (3) @(posedge CLK_I);
        RST_B_I <= 1'b1;
        for (int p = 0; p < 2; p++) begin
            x = {xs(), xs()};
            y = {xs(), xs()};
            z = {xs(), xs()};
            wr(5'h00, x);
            wr(5'h01, y);
            wr(5'h02, z);
            run({3'h0, 13'h01c0, 7'h1f, 1'b1, p[0], 7'h0}, 2'h0, 32'h0, 32'h0, 0, 1'b0);
            a9 = x * x + y * y + z * z;
            m = a9 >> 1;
            c = ~m;
            rd(5'h00, c * x);
            rd(5'h01, c * y);
            rd(5'h02, c * z);
            rd(5'h03, m);
            rd(5'h0a, c);
            rd(5'h09, a9);
        end
        run({3'h0, 13'h01c0, 7'h1f, 1'b0, 1'b1, 7'h0}, 2'h0, 32'h0, 32'h0, 0, 1'b1);
        run(32'h0, 2'h0, 32'h0, 32'h0, 0, 1'b1);
        rd(5'h00, c * x);
        for (int i = 0; i < 16; i++)
            hmem[i] = xs();
        host_pointer_register = 32'h100;
        for (int k = 0; k < 7; k++) begin
            coproc_scale_source = 4'(xs() % 10);
            x = {xs(), xs()};
            y = {xs(), xs()};
            z = {xs(), xs()};
            wr(5'h00, x);
            wr(5'h01, y);
            wr(5'h02, z);
            host_operand_first = xs();
            host_operand_second = xs();
            if (k == 5) begin
                host_operand_first = hmem[host_pointer_register[8:5]];
                host_pointer_register += 32'h20;
                host_operand_second = hmem[host_pointer_register[8:5]];
                host_pointer_register += 32'h20;
            end
            if (k == 6) begin
                host_pointer_register -= 32'h20;
                host_operand_first = hmem[host_pointer_register[8:5]];
            end
            sv = sk[k] ? {host_operand_second, host_operand_first} : {32'h0, host_operand_first};
            if (xk[k] == 2'h0)
                wr({1'b1, coproc_scale_source}, sv);
            run({3'h0, coproc_scale_source, 9'h0e0, 7'h0f, tk[k], sk[k], 7'h0}, xk[k], host_operand_first,
                host_operand_second, xk[k] == 2'h0 ? 0 : (sk[k] ? 2 : 1), 1'b0);
            rd({1'b1, coproc_scale_source}, sv);
            rd(5'h00, x * sv);
            rd(5'h01, y * sv);
            rd(5'h02, z * sv);
        end
        repeat (3) @(posedge CLK_I);
        end_sim();
    end
endmodule : testbench

bind vns_top vns_chk u_chk (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .INSTR_VALID_I(INSTR_VALID_I),
    .INSTR_WORD_I(INSTR_WORD_I), .XFER_TYPE_I(XFER_TYPE_I), .FPU_DONE_I(FPU_DONE_I), .BUSY_O(BUSY_O),
    .DATA_READY_O(DATA_READY_O), .DONE_O(DONE_O), .ILLEGAL_O(ILLEGAL_O), .FPU_REQ_O(FPU_REQ_O),
    .FPU_OP_O(FPU_OP_O), .FPU_PREC_O(FPU_PREC_O), .FPU_A_O(FPU_A_O), .FPU_B_O(FPU_B_O));
